// ===== src/srcc_top.sv
/*
  System reset and clock source controller: collects reset causes, stretches
  internal ones onto the open-drain external reset pin, keeps the reset-cause
  flags and backup-domain settings across system resets, gates supply
  supervisor features and selects and enables the clock sources.
  Assumes RST_B_IN is the power-on reset, all inputs are synchronous to
  CORE_CLK_IN and the pin pad resolves EXT_RESET_PIN_N from the enable.
*/
`timescale 1ns/100ps
// Behaviour
// - system reset clears all except flags, backup
// - six causes raise a system reset
// - supervisor on when pin high or absent
// - supervisor pin low disables power reset circuitry
// - voltage detector forced off without supervisor
// - bypass: core pin only resets core domain
// - bypass: core pin low blocks debug under reset
// - bypass: no over-drive or under-drive
// - bypass: no standby entry
// - system clock from internal, external or PLL
// - low internal osc clocks watchdog, optional RTC
// - low external osc selectable for RTC
// - every clock source has its own enable
// - external clock from user clock or crystal
// - bypass when both bypass and on bits set
module srcc_top #(
  parameter bit HAS_SUPV_PIN = 1'b1,
  parameter int PULSE_CYCLES = srcc_pkg::RST_PULSE_CYCLES
) (
  input  wire logic                      CORE_CLK_IN,
  input  wire logic                      RST_B_IN,
  input  wire logic                      PSEL_IN,
  input  wire logic                      PENABLE_IN,
  input  wire logic                      PWRITE_IN,
  input  wire logic [srcc_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]               PWDATA_IN,
  output logic      [31:0]               PRDATA_OUT,
  output logic                           PREADY_OUT,
  output logic                           PSLVERR_OUT,
  input  wire logic                      EXT_RESET_PIN_N_IN,
  output logic                           EXT_RESET_PIN_N_OUT,
  output logic                           EXT_RESET_PIN_N_OE_OUT,
  input  wire logic                      WINDOW_WATCHDOG_RST_IN,
  input  wire logic                      INDEPENDENT_WATCHDOG_RST_IN,
  input  wire logic                      LOW_POWER_RST_IN,
  input  wire logic                      INDEPENDENT_WATCHDOG_RUN_IN,
  input  wire logic                      SUPERVISOR_ENABLE_PIN_IN,
  input  wire logic                      REG_BYPASS_IN,
  input  wire logic                      CORE_DOMAIN_RESET_PIN_N_IN,
  output logic                           SYS_RST_N_OUT,
  output logic                           CORE_DOMAIN_RST_N_OUT,
  output logic                           POR_PDR_EN_OUT,
  output logic                           PVD_EN_OUT,
  output logic                           BOR_EN_OUT,
  output logic                           DEBUG_UNDER_RESET_OK_OUT,
  output logic                           CORE_PIN_GPIO_OK_OUT,
  output logic                           OVERDRIVE_EN_OUT,
  output logic                           UNDERDRIVE_EN_OUT,
  output logic                           STANDBY_ENTRY_OUT,
  input  wire srcc_pkg::srcc_osc_t       OSC_READY_IN,
  output srcc_pkg::srcc_osc_t            CLK_EN_OUT,
  output logic                           HSE_DRIVER_EN_OUT,
  output logic                           HSE_BYPASS_OUT,
  output srcc_pkg::srcc_system_clock_t         SYSTEM_CLOCK_SEL_OUT,
  output srcc_pkg::srcc_rtc_kernel_clock_t         RTC_KERNEL_CLOCK_SEL_OUT,
  output logic                           INDEPENDENT_WATCHDOG_CLK_EN_OUT
);

  if (PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("srcc_top: PULSE_CYCLES must be at least 1");
  end

  logic [srcc_pkg::CTRL_W-1:0]  ctrl_q;
  logic [srcc_pkg::BKP_W-1:0]   bkp_q;
  logic [srcc_pkg::CAUSE_W-1:0] flags_q;
  logic [srcc_pkg::CAUSE_W-1:0] flags_set;
  logic [31:0]                  rdata_d;
  logic                         mapped;
  logic                         wr_ok;
  logic                         rd_ok;
  logic                         por_seen_q;
  logic                         sys_rst_q;
  logic                         sw_rst_req;
  logic                         int_cause;
  logic                         stretch_active;
  logic                         supv_on;
  srcc_pkg::srcc_system_clock_t       sys_req;
  srcc_pkg::srcc_system_clock_t       active_q;
  srcc_pkg::srcc_osc_t          en_d;
  logic                         req_ready;

  // APB: one wait state; the transfer completes on the edge where pready is seen
  assign wr_ok  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  assign rd_ok  = PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN;
  assign mapped = (PADDR_IN == srcc_pkg::OFS_CTRL) || (PADDR_IN == srcc_pkg::OFS_STATUS) ||
                  (PADDR_IN == srcc_pkg::OFS_BACKUP);

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PREADY_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PSLVERR_OUT <= 1'b0;
    end else begin
      PSLVERR_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT && !mapped;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (PADDR_IN)
      srcc_pkg::OFS_CTRL: begin
        rdata_d[srcc_pkg::CTRL_W-1:0] = ctrl_q;
      end
      srcc_pkg::OFS_STATUS: begin
        rdata_d[srcc_pkg::STAT_FLAGS_LO +: srcc_pkg::CAUSE_W] = flags_q;
        rdata_d[srcc_pkg::STAT_ACTIVE_LO +: 2]                = active_q;
        rdata_d[srcc_pkg::STAT_READY_LO +: 5]                 = OSC_READY_IN;
        rdata_d[srcc_pkg::STAT_SUPV]                          = supv_on;
        rdata_d[srcc_pkg::STAT_BYPASS]                        = REG_BYPASS_IN;
      end
      srcc_pkg::OFS_BACKUP: begin
        rdata_d[srcc_pkg::BKP_W-1:0] = bkp_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (rd_ok) begin
      PRDATA_OUT <= rdata_d;
    end
  end

  // control register returns to reset value on every system reset
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl_q <= srcc_pkg::CTRL_RST;
    end else if (sys_rst_q) begin
      ctrl_q <= srcc_pkg::CTRL_RST;
    end else if (wr_ok && PADDR_IN == srcc_pkg::OFS_CTRL) begin
      ctrl_q <= PWDATA_IN[srcc_pkg::CTRL_W-1:0];
    end
  end

  // backup domain only follows the power-on reset, not the system reset
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bkp_q <= srcc_pkg::BKP_RST;
    end else if (wr_ok && !sys_rst_q && PADDR_IN == srcc_pkg::OFS_BACKUP) begin
      bkp_q <= PWDATA_IN[srcc_pkg::BKP_W-1:0];
    end
  end

  assign sw_rst_req = wr_ok && !sys_rst_q && PADDR_IN == srcc_pkg::OFS_CTRL && PWDATA_IN[srcc_pkg::CTRL_SWRST];

  // power-on cause is raised once, in the first cycle after release
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      por_seen_q <= 1'b0;
    end else begin
      por_seen_q <= 1'b1;
    end
  end

  // pin cause counts only while this block is not the one pulling the pin
  always_comb begin
    flags_set                       = '0;
    flags_set[srcc_pkg::CAUSE_PIN]  = !EXT_RESET_PIN_N_IN && !EXT_RESET_PIN_N_OE_OUT;
    flags_set[srcc_pkg::CAUSE_WINDOW_WATCHDOG] = WINDOW_WATCHDOG_RST_IN;
    flags_set[srcc_pkg::CAUSE_INDEPENDENT_WATCHDOG] = INDEPENDENT_WATCHDOG_RST_IN;
    flags_set[srcc_pkg::CAUSE_SW]   = sw_rst_req;
    flags_set[srcc_pkg::CAUSE_LP]   = LOW_POWER_RST_IN;
    flags_set[srcc_pkg::CAUSE_POR]  = !por_seen_q;
  end

  // flags survive system resets; a new cause wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      flags_q <= '0;
    end else if (wr_ok && PADDR_IN == srcc_pkg::OFS_STATUS && PWDATA_IN[srcc_pkg::STAT_CLR]) begin
      flags_q <= flags_set;
    end else begin
      flags_q <= flags_q | flags_set;
    end
  end

  assign int_cause = |flags_set[srcc_pkg::CAUSE_POR:srcc_pkg::CAUSE_WINDOW_WATCHDOG];

  srcc_stretch #(
    .CYCLES     (PULSE_CYCLES)
  ) u_stretch (
    .clk_in     (CORE_CLK_IN),
    .rst_b_in   (RST_B_IN),
    .start_in   (int_cause),
    .active_out (stretch_active)
  );

  // open-drain: only ever pulls low, the pad pull-up gives the high level
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      EXT_RESET_PIN_N_OE_OUT <= 1'b0;
      EXT_RESET_PIN_N_OUT    <= 1'b0;
    end else begin
      EXT_RESET_PIN_N_OE_OUT <= stretch_active;
      EXT_RESET_PIN_N_OUT    <= 1'b0;
    end
  end

  // system reset follows the pin, which also carries the stretched internal pulse
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sys_rst_q     <= 1'b1;
      SYS_RST_N_OUT <= 1'b0;
    end else begin
      // a cause seen now already holds reset, so no one-cycle release after power-on
      sys_rst_q     <= !EXT_RESET_PIN_N_IN || stretch_active || int_cause;
      SYS_RST_N_OUT <= EXT_RESET_PIN_N_IN && !stretch_active && !int_cause;
    end
  end

  assign supv_on = !HAS_SUPV_PIN || SUPERVISOR_ENABLE_PIN_IN;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      POR_PDR_EN_OUT <= 1'b1;
      PVD_EN_OUT     <= 1'b0;
      BOR_EN_OUT     <= 1'b0;
    end else begin
      POR_PDR_EN_OUT <= supv_on;
      PVD_EN_OUT     <= supv_on && ctrl_q[srcc_pkg::CTRL_PVD_EN];
      // brownout armed only by its control bit; gated by the supervisor like the voltage detector
      BOR_EN_OUT     <= supv_on && ctrl_q[srcc_pkg::CTRL_BOR_EN];
    end
  end

  // bypass: core pin is a pure reset for the core-domain part the reset pin misses
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      CORE_DOMAIN_RST_N_OUT    <= 1'b0;
      CORE_PIN_GPIO_OK_OUT     <= 1'b0;
      DEBUG_UNDER_RESET_OK_OUT <= 1'b0;
    end else begin
      CORE_DOMAIN_RST_N_OUT    <= !REG_BYPASS_IN || CORE_DOMAIN_RESET_PIN_N_IN;
      CORE_PIN_GPIO_OK_OUT     <= !REG_BYPASS_IN;
      DEBUG_UNDER_RESET_OK_OUT <= !(REG_BYPASS_IN && !CORE_DOMAIN_RESET_PIN_N_IN);
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      OVERDRIVE_EN_OUT  <= 1'b0;
      UNDERDRIVE_EN_OUT <= 1'b0;
      STANDBY_ENTRY_OUT <= 1'b0;
    end else begin
      OVERDRIVE_EN_OUT  <= !REG_BYPASS_IN && ctrl_q[srcc_pkg::CTRL_OVERDRV];
      UNDERDRIVE_EN_OUT <= !REG_BYPASS_IN && ctrl_q[srcc_pkg::CTRL_UNDERDRV];
      STANDBY_ENTRY_OUT <= !REG_BYPASS_IN && ctrl_q[srcc_pkg::CTRL_STANDBY];
    end
  end

  // unused code 3 of the select field falls back to the internal oscillator
  always_comb begin
    unique case (ctrl_q[srcc_pkg::CTRL_SYSSEL_LO +: 2])
      2'h1: begin
        sys_req = srcc_pkg::SRCC_SYS_HSE;
      end
      2'h2: begin
        sys_req = srcc_pkg::SRCC_SYS_PLL;
      end
      default: begin
        sys_req = srcc_pkg::SRCC_SYS_HSI;
      end
    endcase
  end

  always_comb begin
    unique case (sys_req)
      srcc_pkg::SRCC_SYS_HSE: begin
        req_ready = OSC_READY_IN.high_speed_external_osc && ctrl_q[srcc_pkg::CTRL_HSE_ON];
      end
      srcc_pkg::SRCC_SYS_PLL: begin
        req_ready = OSC_READY_IN.pll && ctrl_q[srcc_pkg::CTRL_PLL_ON];
      end
      default: begin
        req_ready = OSC_READY_IN.high_speed_internal_osc;
      end
    endcase
  end

  // switch only onto a running source, so the system never loses its clock
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      active_q <= srcc_pkg::SRCC_SYS_HSI;
    end else if (sys_rst_q) begin
      active_q <= srcc_pkg::SRCC_SYS_HSI;
    end else if (req_ready) begin
      active_q <= sys_req;
    end
  end

  // the active source stays on even if software clears its enable
  always_comb begin
    en_d     = '0;
    en_d.high_speed_internal_osc = ctrl_q[srcc_pkg::CTRL_HSI_ON] || active_q == srcc_pkg::SRCC_SYS_HSI;
    en_d.high_speed_external_osc = ctrl_q[srcc_pkg::CTRL_HSE_ON] || active_q == srcc_pkg::SRCC_SYS_HSE;
    en_d.pll = ctrl_q[srcc_pkg::CTRL_PLL_ON] || active_q == srcc_pkg::SRCC_SYS_PLL;
    en_d.low_speed_internal_osc = ctrl_q[srcc_pkg::CTRL_LSI_ON] || INDEPENDENT_WATCHDOG_RUN_IN;
    en_d.low_speed_external_osc = bkp_q[srcc_pkg::BKP_LSE_ON];
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      CLK_EN_OUT           <= '0;
      SYSTEM_CLOCK_SEL_OUT <= srcc_pkg::SRCC_SYS_HSI;
      INDEPENDENT_WATCHDOG_CLK_EN_OUT      <= 1'b0;
    end else begin
      CLK_EN_OUT           <= en_d;
      SYSTEM_CLOCK_SEL_OUT <= active_q;
      INDEPENDENT_WATCHDOG_CLK_EN_OUT      <= en_d.low_speed_internal_osc;
    end
  end

  // crystal amplifier runs only when on without bypass; bypass needs the bypass bit plus the on bit or HSE as active source
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      HSE_DRIVER_EN_OUT <= 1'b0;
      HSE_BYPASS_OUT    <= 1'b0;
    end else begin
      HSE_DRIVER_EN_OUT <= en_d.high_speed_external_osc && !ctrl_q[srcc_pkg::CTRL_HSE_BYP];
      HSE_BYPASS_OUT    <= en_d.high_speed_external_osc && ctrl_q[srcc_pkg::CTRL_HSE_BYP];
    end
  end

  // rtc kernel clock: low external or low internal oscillator, or none
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RTC_KERNEL_CLOCK_SEL_OUT <= srcc_pkg::SRCC_RTC_NONE;
    end else begin
      unique case (bkp_q[srcc_pkg::BKP_RTCSEL_LO +: 2])
        2'h1: begin
          RTC_KERNEL_CLOCK_SEL_OUT <= srcc_pkg::SRCC_RTC_LSE;
        end
        2'h2: begin
          RTC_KERNEL_CLOCK_SEL_OUT <= srcc_pkg::SRCC_RTC_LSI;
        end
        default: begin
          RTC_KERNEL_CLOCK_SEL_OUT <= srcc_pkg::SRCC_RTC_NONE;
        end
      endcase
    end
  end

endmodule : srcc_top

// ===== inc/srcc_pkg.sv
/*
  Package for the system reset and clock source controller: register map, field
  positions, reset values, timing counts and the carrier types.
  Assumes a 125 MHz core clock and a 32-bit APB register bus.
*/
package srcc_pkg;

  // core clock rate, used to turn times into cycle counts
  localparam int CLK_MHZ          = 125;
  // minimum width of the pulse that drives the external reset pin, in ns
  localparam int RST_PULSE_NS     = 20000;
  localparam int RST_PULSE_CYCLES = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;

  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_BACKUP = 12'h008;

  // control register fields
  localparam int CTRL_HSI_ON    = 0;
  localparam int CTRL_HSE_ON    = 1;
  localparam int CTRL_HSE_BYP   = 2;
  localparam int CTRL_PLL_ON    = 3;
  localparam int CTRL_LSI_ON    = 4;
  localparam int CTRL_PVD_EN    = 5;
  localparam int CTRL_BOR_EN    = 6;
  localparam int CTRL_OVERDRV   = 7;
  localparam int CTRL_UNDERDRV  = 8;
  localparam int CTRL_STANDBY   = 9;
  localparam int CTRL_SYSSEL_LO = 10;
  localparam int CTRL_SWRST     = 31;
  localparam int CTRL_W         = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h001;

  // status register fields
  localparam int STAT_FLAGS_LO  = 0;
  localparam int STAT_CLR       = 8;
  localparam int STAT_ACTIVE_LO = 16;
  localparam int STAT_READY_LO  = 20;
  localparam int STAT_SUPV      = 28;
  localparam int STAT_BYPASS    = 29;

  // backup-domain register fields
  localparam int BKP_LSE_ON     = 0;
  localparam int BKP_RTCSEL_LO  = 1;
  localparam int BKP_W          = 3;
  localparam logic [BKP_W-1:0] BKP_RST = 3'h0;

  // reset-cause flag positions
  localparam int CAUSE_PIN  = 0;
  localparam int CAUSE_WINDOW_WATCHDOG = 1;
  localparam int CAUSE_INDEPENDENT_WATCHDOG = 2;
  localparam int CAUSE_SW   = 3;
  localparam int CAUSE_LP   = 4;
  localparam int CAUSE_POR  = 5;
  localparam int CAUSE_W    = 6;

  typedef enum logic [1:0] {
    SRCC_SYS_HSI,
    SRCC_SYS_HSE,
    SRCC_SYS_PLL
  } srcc_system_clock_t;

  typedef enum logic [1:0] {
    SRCC_RTC_NONE,
    SRCC_RTC_LSE,
    SRCC_RTC_LSI
  } srcc_rtc_kernel_clock_t;

  // one bit per clock source, used for enables and for ready flags
  typedef struct packed {
    logic low_speed_external_osc;
    logic low_speed_internal_osc;
    logic pll;
    logic high_speed_external_osc;
    logic high_speed_internal_osc;
  } srcc_osc_t;

endpackage : srcc_pkg

// ===== src/srcc_stretch.sv
/*
  Pulse stretcher: a one-cycle start yields an active level of at least CYCLES
  clock cycles; a new start while active restarts the count.
  Assumes start is synchronous to clk.
*/
`timescale 1ns/100ps
module srcc_stretch #(
  parameter int CYCLES = 2500
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  output logic      active_out
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("srcc_stretch: CYCLES must be at least 1");
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else if (start_in) begin
      cnt_q <= CW'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_out <= 1'b0;
    end else begin
      active_out <= start_in || (cnt_q > CW'(1));
    end
  end

endmodule : srcc_stretch

// ===== bench/srcc_assertions.sv
/*
  Checker for srcc_top: reset pulse length, cause handling, supervisor gating,
  bypass limits and clock enables.
  Assumes it is bound into srcc_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module srcc_assertions #(
  parameter bit HAS_SUPV_PIN = 1'b1,
  parameter int PULSE_CYCLES = 2500
) (
  input wire logic                CORE_CLK_IN,
  input wire logic                RST_B_IN,
  input wire logic                PREADY_OUT,
  input wire logic                EXT_RESET_PIN_N_IN,
  input wire logic                EXT_RESET_PIN_N_OE_OUT,
  input wire logic                WINDOW_WATCHDOG_RST_IN,
  input wire logic                INDEPENDENT_WATCHDOG_RUN_IN,
  input wire logic                SUPERVISOR_ENABLE_PIN_IN,
  input wire logic                REG_BYPASS_IN,
  input wire logic                CORE_DOMAIN_RESET_PIN_N_IN,
  input wire logic                SYS_RST_N_OUT,
  input wire logic                CORE_DOMAIN_RST_N_OUT,
  input wire logic                POR_PDR_EN_OUT,
  input wire logic                PVD_EN_OUT,
  input wire logic                BOR_EN_OUT,
  input wire logic                DEBUG_UNDER_RESET_OK_OUT,
  input wire logic                CORE_PIN_GPIO_OK_OUT,
  input wire logic                OVERDRIVE_EN_OUT,
  input wire logic                UNDERDRIVE_EN_OUT,
  input wire logic                STANDBY_ENTRY_OUT,
  input wire srcc_pkg::srcc_osc_t CLK_EN_OUT,
  input wire logic                HSE_DRIVER_EN_OUT,
  input wire logic                HSE_BYPASS_OUT,
  input wire logic                INDEPENDENT_WATCHDOG_CLK_EN_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // counts pin-drive cycles; a restart only lengthens the pulse
  int unsigned oe_cnt_q;
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      oe_cnt_q <= 0;
    end else begin
      oe_cnt_q <= EXT_RESET_PIN_N_OE_OUT ? oe_cnt_q + 1 : 0;
    end
  end

  stretch_len_a: assert property ($fell(EXT_RESET_PIN_N_OE_OUT) |-> oe_cnt_q >= PULSE_CYCLES)
    else $error("reset pulse too short");
  cause_pin_a: assert property (WINDOW_WATCHDOG_RST_IN |-> ##[1:2] EXT_RESET_PIN_N_OE_OUT)
    else $error("cause did not drive pin");
  pin_sysrst_a: assert property (!EXT_RESET_PIN_N_IN |-> ##[1:2] !SYS_RST_N_OUT)
    else $error("low pin gave no system reset");
  supv_follow_a: assert property (1'b1 |=> POR_PDR_EN_OUT == ($past(SUPERVISOR_ENABLE_PIN_IN) || !HAS_SUPV_PIN))
    else $error("supervisor enable wrong");
  detector_off_a: assert property (!POR_PDR_EN_OUT |-> !PVD_EN_OUT && !BOR_EN_OUT)
    else $error("detector on without supervisor");
  bypass_limits_a: assert property (REG_BYPASS_IN |=> !OVERDRIVE_EN_OUT && !UNDERDRIVE_EN_OUT
                                    && !STANDBY_ENTRY_OUT && !CORE_PIN_GPIO_OK_OUT)
    else $error("feature left on in bypass");
  debug_block_a: assert property (REG_BYPASS_IN && !CORE_DOMAIN_RESET_PIN_N_IN
                                  |=> !DEBUG_UNDER_RESET_OK_OUT && !CORE_DOMAIN_RST_N_OUT)
    else $error("core pin low did not block");
  hse_mode_a: assert property (HSE_BYPASS_OUT |-> CLK_EN_OUT.high_speed_external_osc && !HSE_DRIVER_EN_OUT)
    else $error("bypass with driver on");
  independent_watchdog_clk_a: assert property (INDEPENDENT_WATCHDOG_RUN_IN |=> INDEPENDENT_WATCHDOG_CLK_EN_OUT && CLK_EN_OUT.low_speed_internal_osc)
    else $error("watchdog clock off");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
endmodule : srcc_assertions

// ===== bench/srcc_supv_model.sv
/*
  External supply supervisor and reset controller on the far side.
  Assumes the bench sets the supply-good levels; the reset pin has a pull-up.
*/
`timescale 1ns/100ps
module srcc_supv_model (
  input  wire logic oe_in,
  input  wire logic vdd_ok_in,
  input  wire logic core_supply_pin_ok_in,
  output logic      pin_n_out,
  output logic      core_pin_n_out
);
  // open drain: either party pulls low, otherwise the pull-up wins
  assign pin_n_out      = !(oe_in || !vdd_ok_in);
  // driven apart from the reset pin so debug under reset stays possible
  assign core_pin_n_out = vdd_ok_in && core_supply_pin_ok_in;
endmodule : srcc_supv_model

// ===== bench/srcc_top_bench.sv
/*
  Self-checking bench for srcc_top with the supervisor model on its pins.
  Assumes the stretch is cut to 4 cycles and the bus answers with one wait state.
*/
`timescale 1ns/100ps
module srcc_top_bench;
  localparam logic [11:0] A_CTL = srcc_pkg::OFS_CTRL, A_ST = srcc_pkg::OFS_STATUS, A_BK = srcc_pkg::OFS_BACKUP;
  logic CORE_CLK_IN = 1'b0, RST_B_IN = 1'b0, PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
  logic WINDOW_WATCHDOG_RST_IN = 1'b0, INDEPENDENT_WATCHDOG_RST_IN = 1'b0, LOW_POWER_RST_IN = 1'b0;
  logic INDEPENDENT_WATCHDOG_RUN_IN = 1'b0, SUPERVISOR_ENABLE_PIN_IN = 1'b1, REG_BYPASS_IN = 1'b0;
  logic [11:0] PADDR_IN = 12'h000;
  logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT;
  logic PREADY_OUT, PSLVERR_OUT, EXT_RESET_PIN_N_IN, EXT_RESET_PIN_N_OUT, EXT_RESET_PIN_N_OE_OUT;
  logic CORE_DOMAIN_RESET_PIN_N_IN, SYS_RST_N_OUT, CORE_DOMAIN_RST_N_OUT, POR_PDR_EN_OUT, PVD_EN_OUT;
  logic BOR_EN_OUT, DEBUG_UNDER_RESET_OK_OUT, CORE_PIN_GPIO_OK_OUT, OVERDRIVE_EN_OUT, UNDERDRIVE_EN_OUT;
  logic STANDBY_ENTRY_OUT, HSE_DRIVER_EN_OUT, HSE_BYPASS_OUT, INDEPENDENT_WATCHDOG_CLK_EN_OUT, vdd_ok = 1'b1, core_supply_pin_ok = 1'b1;
  srcc_pkg::srcc_osc_t    OSC_READY_IN = 5'h1f, CLK_EN_OUT;
  srcc_pkg::srcc_system_clock_t SYSTEM_CLOCK_SEL_OUT;
  srcc_pkg::srcc_rtc_kernel_clock_t RTC_KERNEL_CLOCK_SEL_OUT;
  int          bad_count = 0, checks = 0;
  logic [64:0] exp_q[$];
  logic [64:0] e;

  always #4 CORE_CLK_IN = ~CORE_CLK_IN;

  srcc_top #(.PULSE_CYCLES(4)) uut (.*);
  srcc_supv_model supv (.oe_in(EXT_RESET_PIN_N_OE_OUT), .vdd_ok_in(vdd_ok), .core_supply_pin_ok_in(core_supply_pin_ok),
                        .pin_n_out(EXT_RESET_PIN_N_IN), .core_pin_n_out(CORE_DOMAIN_RESET_PIN_N_IN));

  task automatic conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, want);
    end
  endtask : cmp

  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] want);
    checks++;
    if (got !== want) begin
      bad_count++;
      $display("mismatch t=%0t bus got %h exp %h", $time, got, want);
    end
  endtask : cmp_bus

  // queue entry: {slave error, read mask, read data}
  always @(posedge CORE_CLK_IN) begin
    if (PSEL_IN && PENABLE_IN && PREADY_OUT === 1'b1) begin
      e = exp_q.pop_front();
      cmp_bus({PSLVERR_OUT, PRDATA_OUT & e[63:32]}, {e[64], e[31:0] & e[63:32]});
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
                     input logic [31:0] m, input logic er);
    int n;
    n = 0;
    exp_q.push_back({er, m, x});
    @(posedge CORE_CLK_IN);
    PSEL_IN   <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN  <= a;
    PWDATA_IN <= d;
    @(posedge CORE_CLK_IN);
    PENABLE_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    while (PREADY_OUT !== 1'b1 && n < 20) begin
      @(posedge CORE_CLK_IN);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
    PSEL_IN    <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0, x, m, 1'b0);
  endtask : rd

  task automatic wait_up;
    int n;
    n = 0;
    while (SYS_RST_N_OUT !== 1'b1 && n < 200) begin
      @(posedge CORE_CLK_IN);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      conclude();
    end
  endtask : wait_up

  initial begin
    int          s;
    logic [31:0] c;
    s = $urandom(64934);
    OSC_READY_IN <= srcc_pkg::srcc_osc_t'(5'($urandom) | 5'h07);
    repeat (16) @(posedge CORE_CLK_IN);
    RST_B_IN <= 1'b1;
    wait_up();
    rd(A_ST, {4'h1, 3'h0, OSC_READY_IN, 14'h0, 6'h20}, 32'h31f3_003f);
    rd(A_CTL, 32'h1, 32'hfff);
    rd(A_BK, 32'h0, 32'h7);
    for (int i = 0; i < 3; i++) begin
      c = {20'h0, 2'(i), 5'h0, 2'b01, i[0], 2'b11};
      wr(A_CTL, c);
      repeat (3) @(posedge CORE_CLK_IN);
      cmp(SYSTEM_CLOCK_SEL_OUT, 32'(i));
      cmp({HSE_BYPASS_OUT, HSE_DRIVER_EN_OUT}, {i[0], !i[0]});
      cmp(CLK_EN_OUT, 32'h07);
      rd(A_CTL, c, 32'hfff);
    end
    wr(A_BK, 32'h3);
    repeat (2) @(posedge CORE_CLK_IN);
    cmp({CLK_EN_OUT.low_speed_external_osc, RTC_KERNEL_CLOCK_SEL_OUT}, {1'b1, srcc_pkg::SRCC_RTC_LSE});
    wr(A_BK, 32'h4);
    INDEPENDENT_WATCHDOG_RUN_IN <= 1'b1;
    repeat (2) @(posedge CORE_CLK_IN);
    cmp({INDEPENDENT_WATCHDOG_CLK_EN_OUT, RTC_KERNEL_CLOCK_SEL_OUT}, {1'b1, srcc_pkg::SRCC_RTC_LSI});
    for (int i = 0; i < 4; i++) begin
      wr(A_ST, 32'h100);
      if (i == 2) wr(A_CTL, 32'h8000_0000);
      else {LOW_POWER_RST_IN, INDEPENDENT_WATCHDOG_RST_IN, WINDOW_WATCHDOG_RST_IN} <= {i == 3, i == 1, i == 0};
      @(posedge CORE_CLK_IN);
      {LOW_POWER_RST_IN, INDEPENDENT_WATCHDOG_RST_IN, WINDOW_WATCHDOG_RST_IN} <= 3'h0;
      repeat (2) @(posedge CORE_CLK_IN);
      cmp({SYS_RST_N_OUT, EXT_RESET_PIN_N_IN, EXT_RESET_PIN_N_OUT}, 3'h0);
      wait_up();
      rd(A_ST, 32'h1 << (i + 1), 32'h3f);
      rd(A_CTL, 32'h1, 32'hfff);
      rd(A_BK, 32'h4, 32'h7);
    end
    SUPERVISOR_ENABLE_PIN_IN <= 1'b0;
    wr(A_CTL, 32'h21);
    repeat (2) @(posedge CORE_CLK_IN);
    cmp({POR_PDR_EN_OUT, PVD_EN_OUT, BOR_EN_OUT}, 3'h0);
    wr(A_ST, 32'h100);
    vdd_ok <= 1'b0;
    repeat (10) @(posedge CORE_CLK_IN);
    cmp(SYS_RST_N_OUT, 1'b0);
    vdd_ok <= 1'b1;
    wait_up();
    rd(A_ST, 32'h1, 32'h1000_003f);
    SUPERVISOR_ENABLE_PIN_IN <= 1'b1;
    wr(A_CTL, 32'h61);
    repeat (2) @(posedge CORE_CLK_IN);
    cmp({POR_PDR_EN_OUT, PVD_EN_OUT, BOR_EN_OUT}, 3'h7);
    REG_BYPASS_IN <= 1'b1;
    wr(A_CTL, 32'h381);
    core_supply_pin_ok <= 1'b0;
    repeat (3) @(posedge CORE_CLK_IN);
    cmp({OVERDRIVE_EN_OUT, UNDERDRIVE_EN_OUT, STANDBY_ENTRY_OUT, CORE_PIN_GPIO_OK_OUT,
         DEBUG_UNDER_RESET_OK_OUT, CORE_DOMAIN_RST_N_OUT, SYS_RST_N_OUT}, 7'h01);
    core_supply_pin_ok <= 1'b1;
    repeat (3) @(posedge CORE_CLK_IN);
    cmp({DEBUG_UNDER_RESET_OK_OUT, CORE_DOMAIN_RST_N_OUT}, 2'h3);
    REG_BYPASS_IN <= 1'b0;
    repeat (3) @(posedge CORE_CLK_IN);
    cmp({OVERDRIVE_EN_OUT, UNDERDRIVE_EN_OUT, STANDBY_ENTRY_OUT, CORE_PIN_GPIO_OK_OUT}, 4'hf);
    apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
    apb(1'b1, 12'h00c, 32'h5, 32'h0, 32'h0, 1'b1);
    // a second power-on reset must clear the backup settings too
    RST_B_IN <= 1'b0;
    repeat (2) @(posedge CORE_CLK_IN);
    RST_B_IN <= 1'b1;
    wait_up();
    rd(A_BK, 32'h0, 32'h7);
    conclude();
  end
endmodule : srcc_top_bench

bind srcc_top srcc_assertions #(.HAS_SUPV_PIN(HAS_SUPV_PIN), .PULSE_CYCLES(PULSE_CYCLES)) chk (.*);
